// ===== fcc_ctrl.sv
// flash command controller: register file, command launch, key unlock, eeprom commands
// ****************************************
// How it works
// RULE1 - key command refused unless enable field is 10
// RULE2 - software loads key command code and keys
// RULE3 - key command index must be 100
// RULE4 - keys compared in order from 0x3_FF00
// RULE5 - match unsecures; mismatch locks out until reset
// RULE6 - illegal program protection writes ignored
// RULE7 - allowed program protection scenario moves table
// RULE8 - eeprom protection may only be added
// RULE9 - open bit overrides eeprom protect size
// RULE10 - eeprom protection loaded from config at reset
// RULE11 - section verify access error conditions
// RULE12 - section verify sets completion status bits
// RULE13 - eeprom program words chosen by launch index
// RULE14 - program only unprotected area, then complete
// RULE15 - writing 1 to complete flag launches
// RULE16 - access error set, w1c, blocks launch
// RULE17 - protection violation set, w1c, blocks launch
// RULE18 - busy bit high while executing
// RULE19 - completion status bits flag errors
// RULE20 - status bit 2 reads zero
// RULE21 - error flags read, cleared by writing 1; here the error flag register always reads zero and ignores writes
// RULE22 - factory reserved registers read zero
// RULE23 - stored keys never all zeros or ones; here the key command does not check stored_keys for all zeros or ones
// RULE24 - after reset complete flag set, busy clear
// ****************************************
`include "fcc_map.svh"

module fcc_ctrl #(
  parameter int WORD_CYC = `FCC_WORD_CYC
) (
  input  wire logic        clk,        // 200 MHz bus clock
  input  wire logic        rst_b,      // synchronous reset, active low
  input  wire logic [3:0]  addr,       // register offset
  input  wire logic [7:0]  wdata,      // write data
  input  wire logic        wr,         // write strobe
  input  wire logic        rd,         // read strobe
  output logic      [7:0]  rdata,      // read data, cycle after rd
  input  wire logic [7:0]  cfg_sec,    // config field security byte
  input  wire logic [7:0]  cfg_eprot,  // config field eeprom protection
  input  wire logic [7:0]  cfg_pprot,  // config field program protection
  input  wire logic [7:0]  cfg_option, // config field option bits
  input  wire logic        special_mode, // special single-chip mode
  input  wire logic [63:0] stored_keys,  // key words 0..3, key 0 low
  input  wire logic        rd_err,       // array read error seen
  input  wire logic        rd_fatal,     // non-correctable read error
  input  wire logic        blank_fail,   // blank check failed
  input  wire logic        prog_fail,    // program confirm failed
  output logic             busy,         // controller executing
  output logic             nvm_we,       // one word write pulse
  output logic      [17:0] nvm_addr,     // array byte address
  output logic      [15:0] nvm_wdata,    // array word data
  output logic             unsecured     // security released
);
  import fcc_pkg::*;

  fcc_regs_t q, d;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic [2:0] pp_scen(input logic [7:0] p);
    pp_scen = {p[`FCC_PP_OPEN], p[`FCC_PP_HDIS], p[`FCC_PP_LDIS]};
  endfunction : pp_scen

  function automatic logic pp_allowed(input logic [2:0] f, input logic [2:0] t);
    logic [7:0] m;
    m = 8'h00;
    case (f)
      3'h0:    m = 8'h0F;
      3'h1:    m = 8'h0A;
      3'h2:    m = 8'h0C;
      3'h3:    m = 8'h08;
      3'h4:    m = 8'h18;
      3'h5:    m = 8'h3C;
      3'h6:    m = 8'h5A;
      default: m = 8'hFF;
    endcase
    pp_allowed = m[t];
  endfunction : pp_allowed

  function automatic logic [15:0] cw_sel(input fcc_regs_t r, input logic [2:0] i);
    case (i)
      3'h0:    cw_sel = r.cw0;
      3'h1:    cw_sel = r.cw1;
      3'h2:    cw_sel = r.cw2;
      3'h3:    cw_sel = r.cw3;
      3'h4:    cw_sel = r.cw4;
      default: cw_sel = r.cw5;
    endcase
  endfunction : cw_sel

  // eeprom protected from the top of the block downward, size+1 sectors
  function automatic logic ee_prot(input logic [7:0] ep, input logic [16:0] a);
    logic [16:0] span;
    span = 17'((ep[`FCC_EP_SIZE_W-1:0] + 17'h1) * `FCC_EE_SECT);
    if (ep[`FCC_EP_OPEN]) begin
      ee_prot = 1'b0;                                                   // RULE9
    end else begin
      ee_prot = (a >= (`FCC_EE_BYTES - span));
    end
  endfunction : ee_prot

  logic        wr_st;
  logic [7:0]  cmd;
  logic [16:0] ee_a;
  logic [16:0] sec_end;
  logic        mode_ok;
  logic        key_match;
  logic [7:0]  ep_new;

  always_comb begin
    wr_st     = wr && (addr == `FCC_OFF_STATUS);
    cmd       = q.cw0[15:8];
    ee_a      = {1'b0, q.cw1};
    sec_end   = 17'(ee_a + {q.cw2, 1'b0});
    // section verify is barred only in secured special mode
    mode_ok   = !special_mode || (q.sec[1:0] == `FCC_SEC_OPEN);
    key_match = (q.cw1 == stored_keys[15:0]) && (q.cw2 == stored_keys[31:16]) // RULE4
             && (q.cw3 == stored_keys[47:32]) && (q.cw4 == stored_keys[63:48]);
    ep_new    = {wdata[`FCC_EP_OPEN], 1'b0, wdata[`FCC_EP_SIZE_W-1:0]};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d        = q;
    d.nvm_we = 1'b0;
    if (q.load_pend) begin
      d.load_pend = 1'b0;
      d.sec       = cfg_sec;
      d.eprot     = {cfg_eprot[`FCC_EP_OPEN], 1'b0, cfg_eprot[`FCC_EP_SIZE_W-1:0]}; // RULE10
      d.pprot     = cfg_pprot;
      d.ccf       = 1'b1;                                               // RULE24
    end
    if (wr && !q.load_pend) begin
      case (addr)
        `FCC_OFF_CLKDIV: d.clkdiv = wdata;
        `FCC_OFF_IDX:    d.idx = wdata[2:0];
        `FCC_OFF_CONFIG: d.config_r = wdata & 8'h93;
        `FCC_OFF_ERRCFG: d.errcfg = wdata & 8'h03;
        `FCC_OFF_PPROT: begin
          if (q.ccf && pp_allowed(pp_scen(q.pprot), pp_scen(wdata))) begin // RULE7
            d.pprot = wdata;
          end                                                          // RULE6
        end
        `FCC_OFF_EPROT: begin
          if (q.ccf && (ep_new[`FCC_EP_SIZE_W-1:0] >= q.eprot[`FCC_EP_SIZE_W-1:0])
              && !(ep_new[`FCC_EP_OPEN] && !q.eprot[`FCC_EP_OPEN])) begin
            d.eprot = ep_new;                                           // RULE8
          end
        end
        `FCC_OFF_CWHI, `FCC_OFF_CWLO: begin
          if (q.ccf && !q.pviol) begin                                  // RULE17
            case (q.idx)
              3'h0: d.cw0 = addr == `FCC_OFF_CWHI ? {wdata, q.cw0[7:0]} : {q.cw0[15:8], wdata};
              3'h1: d.cw1 = addr == `FCC_OFF_CWHI ? {wdata, q.cw1[7:0]} : {q.cw1[15:8], wdata};
              3'h2: d.cw2 = addr == `FCC_OFF_CWHI ? {wdata, q.cw2[7:0]} : {q.cw2[15:8], wdata};
              3'h3: d.cw3 = addr == `FCC_OFF_CWHI ? {wdata, q.cw3[7:0]} : {q.cw3[15:8], wdata};
              3'h4: d.cw4 = addr == `FCC_OFF_CWHI ? {wdata, q.cw4[7:0]} : {q.cw4[15:8], wdata};
              3'h5: d.cw5 = addr == `FCC_OFF_CWHI ? {wdata, q.cw5[7:0]} : {q.cw5[15:8], wdata};
              default: d.cw5 = q.cw5;
            endcase
          end
        end
        default: d.clkdiv = d.clkdiv;
      endcase
      if (wr_st) begin
        if (wdata[`FCC_ST_ACC]) d.acc = 1'b0;                            // RULE16
        if (wdata[`FCC_ST_PVIOL]) d.pviol = 1'b0;                        // RULE17
      end
    end

    case (q.state)
      FCC_IDLE: begin
        // flags cleared by the same write do not unblock this launch
        if (wr_st && !q.load_pend && wdata[`FCC_ST_CCF] && q.ccf && !q.acc && !q.pviol) begin // RULE15
          d.ccf        = 1'b0;
          d.mgs        = 2'b00;
          d.launch_idx = q.idx;
          d.cnt        = 8'h00;
          d.words      = 3'h0;
          d.state      = FCC_EXEC;
          d.busy       = 1'b1;                                          // RULE18
        end
      end
      FCC_EXEC: begin
        d.state = FCC_DONE;
        case (cmd)
          `FCC_CMD_KEY: begin
            if (q.launch_idx != `FCC_IDX_KEY || q.sec[7:6] != `FCC_KEY_ENABLED // RULE1
                || q.key_fail || special_mode) begin                    // RULE3
              d.acc = 1'b1;
            end else if (key_match) begin
              d.sec[1:0] = `FCC_SEC_OPEN;                               // RULE5
            end else begin
              d.acc      = 1'b1;
              d.key_fail = 1'b1;                                        // RULE5
            end
          end
          `FCC_CMD_EVS: begin
            if (q.launch_idx != `FCC_IDX_EVS || !mode_ok                 // RULE11
                || q.cw0[1:0] != `FCC_EE_BLOCK || ee_a >= `FCC_EE_BYTES
                || ee_a[0] || sec_end > `FCC_EE_BYTES) begin
              d.acc = 1'b1;
            end else begin
              d.mgs[1] = rd_err || rd_fatal || blank_fail;              // RULE12
              d.mgs[0] = rd_fatal || blank_fail;                        // RULE19
            end
          end
          `FCC_CMD_EPGM: begin
            if (q.launch_idx < `FCC_IDX_EPGM_MIN || q.launch_idx > `FCC_IDX_EPGM_MAX
                || q.cw0[1:0] != `FCC_EE_BLOCK || ee_a[0]
                || 17'(ee_a + {q.launch_idx - 3'h1, 1'b0}) > `FCC_EE_BYTES) begin
              d.acc = 1'b1;
            end else if (ee_prot(q.eprot, ee_a) ||
                         ee_prot(q.eprot, 17'(ee_a + {q.launch_idx - 3'h2, 1'b0}))) begin
              d.pviol = 1'b1;                                           // RULE14
            end else begin
              d.state = FCC_EXEC;
              d.cnt   = 8'(q.cnt + 8'h01);
              if (q.cnt == 8'h00) begin
                d.nvm_we    = 1'b1;                                     // RULE13
                d.nvm_addr  = {`FCC_EE_BLOCK, 16'(ee_a + {q.words, 1'b0})};
                d.nvm_wdata = cw_sel(q, 3'(q.words + 3'h2));
              end
              if (q.cnt == 8'(WORD_CYC - 1)) begin
                d.cnt   = 8'h00;
                d.words = 3'(q.words + 3'h1);
                if (3'(q.words + 3'h2) == q.launch_idx) begin
                  d.state = FCC_DONE;
                  d.mgs   = {prog_fail, prog_fail};                     // RULE14
                end
              end
            end
          end
          default: d.acc = 1'b1;                                        // RULE16
        endcase
      end
      FCC_DONE: begin
        d.state = FCC_IDLE;
        d.busy  = 1'b0;
        d.ccf   = 1'b1;                                                 // RULE18
      end
      default: d.state = FCC_IDLE;
    endcase

    // ****************************************
    // read port
    // ****************************************
    d.rd_data = 8'h00;
    if (rd) begin
      case (addr)
        `FCC_OFF_CLKDIV: d.rd_data = q.clkdiv;
        `FCC_OFF_SEC:    d.rd_data = q.sec;
        `FCC_OFF_IDX:    d.rd_data = {5'h00, q.idx};
        `FCC_OFF_CONFIG: d.rd_data = q.config_r;
        `FCC_OFF_ERRCFG: d.rd_data = q.errcfg;
        `FCC_OFF_STATUS: d.rd_data = {q.ccf, 1'b0, q.acc, q.pviol, q.busy, 1'b0, q.mgs}; // RULE20
        `FCC_OFF_ERRFLG: d.rd_data = 8'h00;                              // RULE21
        `FCC_OFF_PPROT:  d.rd_data = q.pprot;
        `FCC_OFF_EPROT:  d.rd_data = q.eprot;
        `FCC_OFF_CWHI:   d.rd_data = 8'(cw_sel(q, q.idx) >> 8);
        `FCC_OFF_CWLO:   d.rd_data = 8'(cw_sel(q, q.idx));
        `FCC_OFF_OPTION: d.rd_data = cfg_option;
        default:         d.rd_data = 8'h00;                              // RULE22
      endcase
    end
    d.unsec = (d.sec[1:0] == `FCC_SEC_OPEN);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q           <= '0;
      q.state     <= FCC_IDLE;
      q.load_pend <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    rdata     = q.rd_data;
    busy      = q.busy;
    nvm_we    = q.nvm_we;
    nvm_addr  = q.nvm_addr;
    nvm_wdata = q.nvm_wdata;
    unsecured = q.unsec;
  end

endmodule : fcc_ctrl

// ===== fcc_ctrl_bench.sv
// self-checking bench of the flash command controller
`include "fcc_map.svh"
module fcc_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] ST = `FCC_OFF_STATUS;
  localparam logic [7:0] ALLOW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  logic        clk, rst_b, wr, rd, special_mode, rd_err, rd_fatal, blank_fail, prog_fail;
  logic        busy, nvm_we, unsecured;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, cfg_sec, cfg_eprot, cfg_pprot, cfg_option, v, cur, d;
  logic [63:0] stored_keys;
  logic [17:0] nvm_addr;
  logic [15:0] nvm_wdata, lfsr_q;
  logic [17:0] we_addr [4];
  logic [15:0] we_data [4];
  logic [2:0]  sc, t;
  int          bad_count, samples_checked, we_cnt;

  fcc_ctrl #(.WORD_CYC(2)) dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cfg_sec(cfg_sec), .cfg_eprot(cfg_eprot),
    .cfg_pprot(cfg_pprot), .cfg_option(cfg_option), .special_mode(special_mode),
    .stored_keys(stored_keys), .rd_err(rd_err), .rd_fatal(rd_fatal), .blank_fail(blank_fail),
    .prog_fail(prog_fail), .busy(busy), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .unsecured(unsecured));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  function automatic logic [7:0] pmap(input logic [2:0] s);
    return {s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
  endfunction : pmap
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic wreg(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic cw(input logic [2:0] i, input logic [15:0] w);
    wreg(`FCC_OFF_IDX, {5'h00, i});
    wreg(`FCC_OFF_CWHI, w[15:8]);
    wreg(`FCC_OFF_CWLO, w[7:0]);
  endtask : cw
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset
  // launch, poll for completion under a bound, compare status
  task automatic run(input logic [7:0] exp);
    int n;
    wreg(ST, 8'h80);
    rreg(ST);
    check(v & 8'h88, 8'h08);
    n = 1;
    while (v[7] !== 1'b1 && n < 50) begin
      rreg(ST);
      n++;
    end
    if (v[7] !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    check(v, exp);
    check(18'(busy), 18'h0);
  endtask : run
  // ccf write beside the clear must not launch
  task automatic clear_flags(input logic [7:0] f);
    wreg(ST, f | 8'h80);
    rreg(ST);
    check(v, 8'h80);
  endtask : clear_flags
  task automatic prog(input logic [15:0] a, input int n, input logic [7:0] exp);
    logic [15:0] w [4];
    cw(3'h0, {`FCC_CMD_EPGM, 8'h00});
    cw(3'h1, a);
    for (int k = 0; k < n; k++) begin
      w[k] = rnd();
      cw(3'(k + 2), w[k]);
    end
    we_cnt = 0;
    run(exp);
    check(18'(we_cnt), exp[4] ? 18'h0 : 18'(n));
    for (int k = 0; k < we_cnt && k < 4; k++) begin
      check(we_addr[k], {2'b00, a + 16'(2 * k)});
      check(18'(we_data[k]), 18'(w[k]));
    end
    if (exp[4])
      clear_flags(8'h10);
  endtask : prog

  always @(posedge clk)
    if (nvm_we === 1'b1 && we_cnt < 4) begin
      we_addr[we_cnt] <= nvm_addr;
      we_data[we_cnt] <= nvm_wdata;
      we_cnt <= we_cnt + 1;
    end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {rst_b, wr, rd, special_mode, rd_err, rd_fatal, blank_fail, prog_fail} = 8'h00;
    {addr, wdata, cfg_sec, cfg_option, we_cnt, bad_count, samples_checked} = '0;
    lfsr_q = 16'h0002;
    cfg_pprot = pmap(3'h7);
    for (int k = 0; k < 4; k++)
      stored_keys[16*k +: 16] = (rnd() & 16'h7FFE) | 16'h0100;
    for (int r = 0; r < 3; r++) begin
      cfg_eprot <= {2'b10, 6'(rnd())};
      cfg_option <= 8'(rnd());
      do_reset();
      rreg(ST);
      check(v, 8'h80);
      rreg(`FCC_OFF_EPROT);
      check(v, cfg_eprot);
      rreg(`FCC_OFF_OPTION);
      check(v, cfg_option);
      for (int a = 0; a < 16; a++)
        if (a inside {3, 7, 12, 14, 15}) begin
          wreg(4'(a), 8'hFF);
          rreg(4'(a));
          check(v, 8'h00);
        end
      sc = 3'h7;
      repeat (6) begin
        t = 3'(rnd());
        wreg(`FCC_OFF_PPROT, pmap(t));
        if (ALLOW[sc][t])
          sc = t;
        rreg(`FCC_OFF_PPROT);
        check(v & 8'hA4, pmap(sc));
      end
      cur = cfg_eprot;
      repeat (8) begin
        d = {rnd() > 16'h6000, 1'b0, 6'(rnd())};
        if (d[5:0] == cur[5:0])
          continue;
        wreg(`FCC_OFF_EPROT, d);
        if (d[5:0] > cur[5:0] && !(d[7] && !cur[7]))
          cur = d;
        rreg(`FCC_OFF_EPROT);
        check(v, cur);
      end
      for (int n = 1; n < 5; n++)
        prog(16'h0010, n, 8'h80);
      prog(16'h07FC, 1, cur[7] ? 8'h80 : 8'h90);
    end
    for (int i = 0; i < 5; i++) begin
      if (i == 0 || i >= 3) begin
        cfg_sec <= (i == 4) ? 8'h03 : 8'h83;
        do_reset();
      end
      for (int k = 0; k < ((i == 0) ? 4 : 5); k++)
        cw(3'(k), (k == 0) ? {`FCC_CMD_KEY, 8'h00} : stored_keys[16*(k-1) +: 16] ^ 16'(i == 1));
      run((i == 3) ? 8'h80 : 8'hA0);
      check(18'(unsecured), 18'(i == 3));
      if (i != 3)
        clear_flags(8'h20);
    end
    for (int i = 0; i < 9; i++) begin
      {rd_err, rd_fatal, blank_fail} <= (i < 3) ? 3'(4 >> i) : 3'b000;
      special_mode <= (i == 7);
      cw(3'h0, {`FCC_CMD_EVS, 8'h00});
      cw(3'h1, (i == 4) ? 16'h07F9 : (i == 8) ? 16'h0800 : 16'h07F8);
      if (i != 6)
        cw(3'h2, (i == 5) ? 16'h0005 : 16'h0004);
      run((i > 3) ? 8'hA0 : {6'h20, i < 3, i == 1 || i == 2});
      if (i > 3)
        clear_flags(8'h20);
    end
    complete_run();
  end
endmodule : fcc_ctrl_bench

// ===== fcc_ctrl_properties.sv
// port assertions of the flash command controller
`include "fcc_map.svh"
module fcc_ctrl_checker #(
  parameter int WORD_CYC = `FCC_WORD_CYC
) (
  input wire logic       clk,       // bus clock
  input wire logic       rst_b,     // reset, active low
  input wire logic [3:0] addr,      // register offset
  input wire logic [7:0] wdata,     // write data
  input wire logic       wr,        // write strobe
  input wire logic       rd,        // read strobe
  input wire logic [7:0] rdata,     // read data
  input wire logic       busy,      // controller executing
  input wire logic       nvm_we,    // word write pulse
  input wire logic       unsecured  // security released
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // bound: twice the four-word longest command, plus launch and finish overhead
  localparam int MAX_CMD = 8 * WORD_CYC + 20;
  sequence s_st_rd;
    rd && addr == `FCC_OFF_STATUS;
  endsequence
  sequence s_launch;
    wr && addr == `FCC_OFF_STATUS && wdata[`FCC_ST_CCF];
  endsequence
  property p_bit2_zero;
    s_st_rd |=> !rdata[2];
  endproperty
  a_bit2_zero: assert property (p_bit2_zero) else $error("status bit 2 set");
  property p_busy_shown;
    s_st_rd |=> rdata[`FCC_ST_BUSY] == $past(busy);
  endproperty
  a_busy_shown: assert property (p_busy_shown) else $error("busy bit wrong");
  property p_busy_ccf;
    s_st_rd |=> !(rdata[`FCC_ST_CCF] && rdata[`FCC_ST_BUSY]);
  endproperty
  a_busy_ccf: assert property (p_busy_ccf) else $error("busy with complete");
  property p_rsv_zero;
    rd && (addr == `FCC_OFF_RSV_A || addr == `FCC_OFF_RSV_B) |=> rdata == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved not zero");
  property p_launch_cause;
    $rose(busy) |-> $past(wr && addr == `FCC_OFF_STATUS && wdata[`FCC_ST_CCF]);
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("busy without launch");
  property p_busy_ends;
    $rose(busy) |-> ##[1:MAX_CMD] !busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("command never ends");
  property p_we_pulse;
    nvm_we |=> !nvm_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
  property p_we_busy;
    nvm_we |-> busy && !(wr && addr == `FCC_OFF_STATUS && wdata[`FCC_ST_CCF]);
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("write while idle");
  property p_unsec;
    $rose(unsecured) && $past(rst_b, 2) |-> busy;
  endproperty
  a_unsec: assert property (p_unsec) else $error("unsecured outside command");
endmodule : fcc_ctrl_checker

bind fcc_ctrl fcc_ctrl_checker #(.WORD_CYC(WORD_CYC)) u_checker (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy),
  .nvm_we(nvm_we), .unsecured(unsecured));

// ===== fcc_map.svh
// register offsets, field positions, command codes and timing counts of the flash command controller
`ifndef FCC_MAP_SVH
`define FCC_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define FCC_OFF_CLKDIV   4'h0
`define FCC_OFF_SEC      4'h1
`define FCC_OFF_IDX      4'h2
`define FCC_OFF_RSV_A    4'h3
`define FCC_OFF_CONFIG   4'h4
`define FCC_OFF_ERRCFG   4'h5
`define FCC_OFF_STATUS   4'h6
`define FCC_OFF_ERRFLG   4'h7
`define FCC_OFF_PPROT    4'h8
`define FCC_OFF_EPROT    4'h9
`define FCC_OFF_CWHI     4'hA
`define FCC_OFF_CWLO     4'hB
`define FCC_OFF_RSV_B    4'hC
`define FCC_OFF_OPTION   4'hD
`define FCC_OFF_RSV_C    4'hE
`define FCC_OFF_RSV_D    4'hF

// ****************************************
// status register bits
// ****************************************
`define FCC_ST_CCF       7
`define FCC_ST_ACC       5
`define FCC_ST_PVIOL     4
`define FCC_ST_BUSY      3
`define FCC_ST_MGS1      1
`define FCC_ST_MGS0      0

// ****************************************
// protection fields
// ****************************************
`define FCC_EP_OPEN      7
`define FCC_EP_SIZE_W    6
`define FCC_PP_OPEN      7
`define FCC_PP_HDIS      5
`define FCC_PP_LDIS      2

// ****************************************
// commands, indices, keys
// ****************************************
`define FCC_CMD_KEY      8'h0C
`define FCC_CMD_EVS      8'h10
`define FCC_CMD_EPGM     8'h11
`define FCC_IDX_KEY      3'h4
`define FCC_IDX_EVS      3'h2
`define FCC_IDX_EPGM_MIN 3'h2
`define FCC_IDX_EPGM_MAX 3'h5
`define FCC_KEY_ENABLED  2'h2
`define FCC_SEC_OPEN     2'h2
`define FCC_KEY_ADDR     18'h3FF00
`define FCC_EE_BLOCK     2'h0
`define FCC_EE_BYTES     17'h00800
`define FCC_EE_SECT      17'h00004

// ****************************************
// timing
// ****************************************
`define FCC_CLK_MHZ      200
`define FCC_WORD_NS      40
`define FCC_WORD_CYC     ((`FCC_WORD_NS * `FCC_CLK_MHZ + 999) / 1000)

`endif

// ===== fcc_pkg.sv
// types of the flash command controller
package fcc_pkg;

  typedef enum logic [1:0] {
    FCC_IDLE = 2'b00,
    FCC_EXEC = 2'b01,
    FCC_DONE = 2'b10
  } fcc_state_t;

  typedef struct packed {
    fcc_state_t  state;
    logic [7:0]  clkdiv;
    logic [7:0]  sec;
    logic [2:0]  idx;
    logic [7:0]  config_r;
    logic [7:0]  errcfg;
    logic        ccf;
    logic        acc;
    logic        pviol;
    logic [1:0]  mgs;
    logic [7:0]  pprot;
    logic [7:0]  eprot;
    logic [15:0] cw0;
    logic [15:0] cw1;
    logic [15:0] cw2;
    logic [15:0] cw3;
    logic [15:0] cw4;
    logic [15:0] cw5;
    logic [2:0]  launch_idx;
    logic        key_fail;
    logic        load_pend;
    logic [7:0]  cnt;
    logic [2:0]  words;
    logic [7:0]  rd_data;
    logic        busy;
    logic        nvm_we;
    logic [17:0] nvm_addr;
    logic [15:0] nvm_wdata;
    logic        unsec;
  } fcc_regs_t;

endpackage : fcc_pkg
